/* File: design/cmm_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmm_defs.vh"

module cmm_regs #(
    parameter [7:0] LANE_CLASS = `CMM_LANE_CLASS1,
    parameter [4:0] DEVAD = `CMM_MDIO_DEVAD
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Management pins
    input wire mdc,
    input wire mdio_i,
    output wire mdio_o,
    output wire mdio_oe,
    input wire [4:0] prtad_pins,
    // Control pin two and tick
    input wire programmable_control_pin_two,
    input wire internal_tick,
    output reg perf_monitor_tick,
    output reg pin_two_ctl,
    // Transmit power
    output reg tx_shutter,
    output reg [15:0] tx_power_setpoint,
    // Tuning
    input wire [47:0] tx_legacy_min_freq,
    input wire [47:0] rx_legacy_min_freq,
    input wire [47:0] tx_cur_freq,
    input wire [47:0] rx_cur_freq,
    output wire [47:0] tx_min_freq,
    output wire [47:0] rx_min_freq,
    output wire tx_hires_mode,
    output wire rx_hires_mode
);

wire [15:0] reg_addr;
wire [15:0] reg_wdata;
wire reg_we;
reg [15:0] reg_rdata;
reg [7:0] pin2_func_r;
reg tick_src_r;
reg tx_hires_en_r;
reg rx_hires_en_r;
reg [15:0] freq_r [0:`CMM_FREQ_RW_COUNT-1];
reg p2_s1, p2_s2, p2_d;
wire [15:0] freq_off = reg_addr - `CMM_ADDR_FREQ_BASE;
wire in_freq = (reg_addr >= `CMM_ADDR_FREQ_BASE) && (reg_addr <= `CMM_ADDR_FREQ_LAST);
wire [47:0] tx_hires_min = {freq_r[0], freq_r[1], freq_r[2]};
wire [47:0] rx_hires_min = {freq_r[3], freq_r[4], freq_r[5]};

////////////////////////////////////////////////////////////////////////////////

cmm_mdio #(
    .DEVAD(DEVAD)
) u_mdio (
    .clk(clk),
    .rstn(rstn),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .prtad_pins(prtad_pins),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_rdata(reg_rdata)
);

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk) begin
    if (!rstn) begin
        pin2_func_r <= `CMM_PIN2_FUNC_RST;
        tick_src_r <= `CMM_OP_CTL_RST;
        tx_hires_en_r <= `CMM_HIRES_EN_RST;
        rx_hires_en_r <= `CMM_HIRES_EN_RST;
        tx_power_setpoint <= `CMM_TX_POWER_RST;
    end else if (reg_we) begin
        case (reg_addr)
            // Reserved codes are stored as written; the host keeps clear of them.
            `CMM_ADDR_PIN2_FUNC: pin2_func_r <= reg_wdata[7:0];
            `CMM_ADDR_OP_CTL: tick_src_r <= reg_wdata[`CMM_BIT_TICK_SRC];
            `CMM_ADDR_TX_CH_CTL: tx_hires_en_r <= reg_wdata[`CMM_BIT_HIRES_EN];
            `CMM_ADDR_RX_CH_CTL: rx_hires_en_r <= reg_wdata[`CMM_BIT_HIRES_EN];
            `CMM_ADDR_TX_POWER: tx_power_setpoint <= reg_wdata;
            default: pin2_func_r <= pin2_func_r;
        endcase
    end
end

// Only the first six words of the block are writable; the rest fall through.
genvar gi;
generate
    for (gi = 0; gi < `CMM_FREQ_RW_COUNT; gi = gi + 1) begin : g_freq
        always @(posedge clk) begin
            if (!rstn)
                freq_r[gi] <= `CMM_FREQ_RST;
            else if (reg_we && in_freq && (freq_off == gi))
                freq_r[gi] <= reg_wdata;
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

always @* begin
    reg_rdata = 16'h0000;
    case (reg_addr)
        `CMM_ADDR_LANE_CLASS: reg_rdata = {8'h00, LANE_CLASS};
        `CMM_ADDR_PIN2_FUNC: reg_rdata = {8'h00, pin2_func_r};
        `CMM_ADDR_OP_CTL: reg_rdata = {5'h00, tick_src_r, 10'h000};
        `CMM_ADDR_TX_CH_CTL: reg_rdata = {5'h00, tx_hires_en_r, 10'h000};
        `CMM_ADDR_RX_CH_CTL: reg_rdata = {5'h00, rx_hires_en_r, 10'h000};
        `CMM_ADDR_TX_POWER: reg_rdata = tx_power_setpoint;
        default: begin
            if (in_freq) begin
                case (freq_off[3:0])
                    4'h0: reg_rdata = freq_r[0];
                    4'h1: reg_rdata = freq_r[1];
                    4'h2: reg_rdata = freq_r[2];
                    4'h3: reg_rdata = freq_r[3];
                    4'h4: reg_rdata = freq_r[4];
                    4'h5: reg_rdata = freq_r[5];
                    4'h6: reg_rdata = tx_cur_freq[47:32];
                    4'h7: reg_rdata = tx_cur_freq[31:16];
                    4'h8: reg_rdata = tx_cur_freq[15:0];
                    4'h9: reg_rdata = rx_cur_freq[47:32];
                    4'hA: reg_rdata = rx_cur_freq[31:16];
                    4'hB: reg_rdata = rx_cur_freq[15:0];
                    default: reg_rdata = 16'h0000;
                endcase
            end
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk) begin
    if (!rstn) begin
        p2_s1 <= 1'b0;
        p2_s2 <= 1'b0;
        p2_d <= 1'b0;
        perf_monitor_tick <= 1'b0;
        pin_two_ctl <= 1'b0;
        tx_shutter <= 1'b0;
    end else begin
        p2_s1 <= programmable_control_pin_two;
        p2_s2 <= p2_s1;
        p2_d <= p2_s2;
        // The external tick is the rising edge seen on pin two.
        if (tick_src_r)
            perf_monitor_tick <= p2_s2 & ~p2_d;
        else
            perf_monitor_tick <= internal_tick;
        // While the function code is 2 (tick) pin two is not a plain control level.
        pin_two_ctl <= (pin2_func_r == `CMM_PIN2_FUNC_TICK) ? 1'b0 : p2_s2;
        tx_shutter <= ($signed(tx_power_setpoint) <= $signed(`CMM_SHUTTER_LIMIT));
    end
end

////////////////////////////////////////////////////////////////////////////////

cmm_tune #(
    .FREQ_W(48)
) u_tx_tune (
    .clk(clk),
    .rstn(rstn),
    .hires_en(tx_hires_en_r),
    .hires_min_freq(tx_hires_min),
    .legacy_min_freq(tx_legacy_min_freq),
    .min_freq(tx_min_freq),
    .hires_mode(tx_hires_mode)
);

cmm_tune #(
    .FREQ_W(48)
) u_rx_tune (
    .clk(clk),
    .rstn(rstn),
    .hires_en(rx_hires_en_r),
    .hires_min_freq(rx_hires_min),
    .legacy_min_freq(rx_legacy_min_freq),
    .min_freq(rx_min_freq),
    .hires_mode(rx_hires_mode)
);

endmodule
`default_nettype wire

/* File: design/cmm_defs.vh */
// How it works
// - Function code 2 in the control-pin-two select field routes the performance-monitor tick to that pin, and the host never writes codes 3 to 127.
// The design only holds pin_two_ctl low for code 2 and takes the tick from pin two whenever bit 10 is set, at any function code.
// - Bit 10 of the operating control register picks the tick source, 0 for the internal tick and 1 for an external tick.
// - With the external source picked, the tick is taken from control pin two instead of a dedicated tick pin.
// - A transmit power setpoint of minus 99 dBm or below shutters the transmit output as far as the hardware can.
// - Bit 10 of the transmit and of the receive channel control register enables the host-set minimum frequency registers of that direction.
// - With that bit set tuning uses the high-resolution registers, and with it clear tuning follows the legacy scheme unchanged.
// - Three transmit and three receive read-write registers together set the first-channel frequency in 1 MHz steps.
// - Minimum-frequency values written while the enable bit allows it become the minimum frequency of the laser calculation.
// - Six read-only registers report the present transmit and receive laser frequency in 1 MHz steps.
// - The twelve frequency registers sit at B490 to B49B, each an unsigned 16-bit value, six writable and six read-only.
// - The read-only host lane field reports 10h, 11h or 12h for module class 1, 2 or 3.
`ifndef CMM_DEFS_VH
`define CMM_DEFS_VH

`define CMM_ADDR_LANE_CLASS 16'h8074
`define CMM_ADDR_PIN2_FUNC 16'hB006
`define CMM_ADDR_OP_CTL 16'hB00B
`define CMM_ADDR_TX_CH_CTL 16'hB400
`define CMM_ADDR_TX_POWER 16'hB410
`define CMM_ADDR_RX_CH_CTL 16'hB420
`define CMM_ADDR_FREQ_BASE 16'hB490
`define CMM_ADDR_FREQ_LAST 16'hB49B
`define CMM_FREQ_RW_COUNT 6

`define CMM_BIT_TICK_SRC 10
`define CMM_BIT_HIRES_EN 10

`define CMM_PIN2_FUNC_TICK 8'h02
`define CMM_PIN2_FUNC_RST 8'h00
`define CMM_OP_CTL_RST 1'b0
`define CMM_HIRES_EN_RST 1'b0
`define CMM_FREQ_RST 16'h0000
// Setpoint is signed in 0.01 dBm steps; -99 dBm is -9900.
`define CMM_SHUTTER_LIMIT 16'hD954
`define CMM_TX_POWER_RST 16'h0000

`define CMM_LANE_CLASS1 8'h10
`define CMM_LANE_CLASS2 8'h11
`define CMM_LANE_CLASS3 8'h12

`define CMM_MDIO_DEVAD 5'h01
`define CMM_MDIO_PREAMBLE 6'd32
`define CMM_MDIO_OP_ADDR 2'b00
`define CMM_MDIO_OP_WRITE 2'b01
`define CMM_MDIO_OP_RDINC 2'b10
`define CMM_MDIO_OP_READ 2'b11

`endif

/* File: design/cmm_tune.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmm_defs.vh"

module cmm_tune #(
    parameter FREQ_W = 48
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Selection
    input wire hires_en,
    input wire [FREQ_W-1:0] hires_min_freq,
    input wire [FREQ_W-1:0] legacy_min_freq,
    // To the laser control
    output reg [FREQ_W-1:0] min_freq,
    output reg hires_mode
);

always @(posedge clk) begin
    if (!rstn) begin
        min_freq <= {FREQ_W{1'b0}};
        hires_mode <= 1'b0;
    end else begin
        hires_mode <= hires_en;
        // The legacy value passes untouched so existing tuning is unchanged.
        min_freq <= hires_en ? hires_min_freq : legacy_min_freq;
    end
end

endmodule
`default_nettype wire

/* File: design/cmm_mdio.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmm_defs.vh"

module cmm_mdio #(
    parameter [4:0] DEVAD = `CMM_MDIO_DEVAD
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Management pins
    input wire mdc,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_oe,
    input wire [4:0] prtad_pins,
    // Register side
    output reg [15:0] reg_addr,
    output reg [15:0] reg_wdata,
    output reg reg_we,
    input wire [15:0] reg_rdata
);

localparam S_PRE = 2'd0;
localparam S_HDR = 2'd1;
localparam S_TA = 2'd2;
localparam S_DAT = 2'd3;

reg mdc_s1, mdc_s2, mdc_d;
reg mdio_s1, mdio_s2;
reg [4:0] prt_s1, prt_s2;
reg [1:0] state_r;
reg [5:0] cnt_r;
reg [13:0] hdr_r;
reg [15:0] sh_r;
reg [1:0] op_r;
reg mine_r;
wire rise = mdc_s2 & ~mdc_d;
wire [13:0] hdr_nxt = {hdr_r[12:0], mdio_s2};
wire [15:0] sh_nxt = {sh_r[14:0], mdio_s2};
wire rd_r = mine_r & op_r[1];

////////////////////////////////////////////////////////////////////////////////

// MDC and MDIO share one synchroniser depth so the sampled bit stays aligned with the edge.
always @(posedge clk) begin
    if (!rstn) begin
        mdc_s1 <= 1'b0;
        mdc_s2 <= 1'b0;
        mdc_d <= 1'b0;
        mdio_s1 <= 1'b1;
        mdio_s2 <= 1'b1;
        prt_s1 <= 5'h00;
        prt_s2 <= 5'h00;
    end else begin
        mdc_s1 <= mdc;
        mdc_s2 <= mdc_s1;
        mdc_d <= mdc_s2;
        mdio_s1 <= mdio_i;
        mdio_s2 <= mdio_s1;
        prt_s1 <= prtad_pins;
        prt_s2 <= prt_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk) begin
    if (!rstn) begin
        state_r <= S_PRE;
        cnt_r <= 6'd0;
        hdr_r <= 14'h0000;
        sh_r <= 16'h0000;
        op_r <= 2'b00;
        mine_r <= 1'b0;
        mdio_o <= 1'b1;
        mdio_oe <= 1'b0;
        reg_addr <= 16'h0000;
        reg_wdata <= 16'h0000;
        reg_we <= 1'b0;
    end else begin
        reg_we <= 1'b0;
        if (rise) begin
            case (state_r)
                S_PRE: begin
                    if (mdio_s2) begin
                        if (cnt_r != `CMM_MDIO_PREAMBLE)
                            cnt_r <= cnt_r + 6'd1;
                    end else if (cnt_r == `CMM_MDIO_PREAMBLE) begin
                        hdr_r <= 14'h0000;
                        cnt_r <= 6'd1;
                        state_r <= S_HDR;
                    end else begin
                        cnt_r <= 6'd0;
                    end
                end
                S_HDR: begin
                    hdr_r <= hdr_nxt;
                    cnt_r <= cnt_r + 6'd1;
                    if (cnt_r == 6'd13) begin
                        op_r <= hdr_nxt[11:10];
                        mine_r <= (hdr_nxt[13:12] == 2'b00) && (hdr_nxt[9:5] == prt_s2) &&
                                  (hdr_nxt[4:0] == DEVAD);
                        sh_r <= reg_rdata;
                        cnt_r <= 6'd0;
                        state_r <= S_TA;
                    end
                end
                S_TA: begin
                    cnt_r <= cnt_r + 6'd1;
                    if (cnt_r == 6'd0) begin
                        mdio_oe <= rd_r;
                        // The output rests high unless this frame is a read addressed here.
                        mdio_o <= ~rd_r;
                    end else begin
                        if (rd_r) begin
                            mdio_o <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end
                        cnt_r <= 6'd0;
                        state_r <= S_DAT;
                    end
                end
                S_DAT: begin
                    sh_r <= sh_nxt;
                    mdio_o <= rd_r ? sh_r[15] : 1'b1;
                    cnt_r <= cnt_r + 6'd1;
                    if (cnt_r == 6'd15) begin
                        mdio_oe <= 1'b0;
                        mdio_o <= 1'b1;
                        if (mine_r) begin
                            case (op_r)
                                `CMM_MDIO_OP_ADDR: reg_addr <= sh_nxt;
                                `CMM_MDIO_OP_WRITE: begin
                                    reg_wdata <= sh_nxt;
                                    reg_we <= 1'b1;
                                end
                                `CMM_MDIO_OP_RDINC: reg_addr <= reg_addr + 16'h0001;
                                default: reg_addr <= reg_addr;
                            endcase
                        end
                        cnt_r <= 6'd0;
                        state_r <= S_PRE;
                    end
                end
                default: state_r <= S_PRE;
            endcase
        end
    end
end

endmodule
`default_nettype wire

/* File: dv/cmm_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cmm_regs_assertions (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Management pins
    input wire mdc,
    input wire mdio_o,
    input wire mdio_oe,
    // Tick and power
    input wire programmable_control_pin_two,
    input wire internal_tick,
    input wire perf_monitor_tick,
    input wire tx_shutter,
    input wire [15:0] tx_power_setpoint,
    // Tuning
    input wire [47:0] tx_legacy_min_freq,
    input wire [47:0] rx_legacy_min_freq,
    input wire [47:0] tx_min_freq,
    input wire [47:0] rx_min_freq,
    input wire tx_hires_mode,
    input wire rx_hires_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // Counts clock pin rises while the device drives the wire.
    reg mdc_r;
    reg [4:0] rise_cnt_r;
    always @(posedge clk) begin
        mdc_r <= mdc;
        if (!rstn || !mdio_oe)
            rise_cnt_r <= 5'h00;
        else if (mdc && !mdc_r)
            rise_cnt_r <= rise_cnt_r + 5'h01;
    end
    sequence s_int_tick;
        $past(internal_tick);
    endsequence
    sequence s_tick_cause;
        $past(internal_tick) || ($past(programmable_control_pin_two, 3) && !$past(programmable_control_pin_two, 4));
    endsequence
    ////////////////////////////////////////
    chk_tick_cause:
        assert property (perf_monitor_tick |-> s_tick_cause) else $error("tick without a cause");
    chk_shutter_level:
        assert property ($stable(tx_power_setpoint) [*2] |-> tx_shutter == ($signed(tx_power_setpoint)
            <= $signed(16'hD954))) else $error("shutter does not match setpoint");
    chk_tx_legacy:
        assert property ($past(rstn) && !tx_hires_mode |-> tx_min_freq == $past(tx_legacy_min_freq))
            else $error("tx minimum not legacy");
    chk_rx_legacy:
        assert property ($past(rstn) && !rx_hires_mode |-> rx_min_freq == $past(rx_legacy_min_freq))
            else $error("rx minimum not legacy");
    chk_ta_zero:
        assert property ($rose(mdio_oe) |-> !mdio_o) else $error("turnaround not low");
    chk_idle_high:
        assert property (!mdio_oe [*2] |-> mdio_o) else $error("idle output not high");
    chk_bit_steady:
        assert property (mdio_oe && $changed(mdio_o) |=> (!mdio_oe || $stable(mdio_o)) [*4])
            else $error("read bit did not stand");
    chk_oe_length:
        assert property ($fell(mdio_oe) |-> rise_cnt_r == 5'h11) else $error("drive length wrong");
    cover property (s_int_tick ##0 perf_monitor_tick);
endmodule
bind cmm_regs cmm_regs_assertions chk (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .programmable_control_pin_two(programmable_control_pin_two), .internal_tick(internal_tick),
    .perf_monitor_tick(perf_monitor_tick), .tx_shutter(tx_shutter), .tx_power_setpoint(tx_power_setpoint),
    .tx_legacy_min_freq(tx_legacy_min_freq), .rx_legacy_min_freq(rx_legacy_min_freq), .tx_min_freq(tx_min_freq),
    .rx_min_freq(rx_min_freq), .tx_hires_mode(tx_hires_mode), .rx_hires_mode(rx_hires_mode));
`default_nettype wire

/* File: dv/cmm_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cmm_host (
    // Clock
    input wire logic clk,
    // Wire level and drive
    input wire logic mdio,
    output logic mdc,
    output logic hdrv,
    output logic hoe
);
    initial begin
        mdc = 1'b0;
        hdrv = 1'b1;
        hoe = 1'b0;
    end
    // Reads release the wire from the turnaround on, so the pull-up shows until the device drives.
    task automatic frame(input logic [1:0] op, input logic [15:0] d, output logic [15:0] q);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'b00, op, 5'h03, 5'h01, 2'b10, d};
        q = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            mdc <= 1'b0;
            hoe <= !(op[1] && i >= 46);
            hdrv <= f[63-i];
            repeat (4) @(negedge clk);
            if (i >= 48)
                q[63-i] = mdio;
            mdc <= 1'b1;
            repeat (3) @(negedge clk);
        end
        hoe <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: dv/cmm_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cmm_regs_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pin2 = 1'b0;
    logic itick = 1'b0;
    logic [47:0] txl = 48'h111122223333;
    logic [47:0] rxl = 48'h444455556666;
    logic [47:0] txc = 48'h123456789ABC;
    logic [47:0] rxc = 48'hFEDCBA987654;
    wire mdc, hdrv, hoe, mdio_o, mdio_oe, ptick, p2ctl, shut, txh, rxh;
    wire [15:0] pset;
    wire [47:0] txm, rxm;
    wire mdio = mdio_oe ? mdio_o : (hoe ? hdrv : 1'b1);
    int num_errors = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    cmm_host host (.clk(clk), .mdio(mdio), .mdc(mdc), .hdrv(hdrv), .hoe(hoe));
    cmm_regs #(.LANE_CLASS(8'h11), .DEVAD(5'h01)) dut (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .prtad_pins(5'h03), .programmable_control_pin_two(pin2),
        .internal_tick(itick), .perf_monitor_tick(ptick), .pin_two_ctl(p2ctl), .tx_shutter(shut),
        .tx_power_setpoint(pset), .tx_legacy_min_freq(txl), .rx_legacy_min_freq(rxl), .tx_cur_freq(txc),
        .rx_cur_freq(rxc), .tx_min_freq(txm), .rx_min_freq(rxm), .tx_hires_mode(txh), .rx_hires_mode(rxh));
    ////////////////////////////////////////
    task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.frame(2'b00, a, q);
        host.frame(2'b01, d, q);
        repeat (8) @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] q;
        host.frame(2'b00, a, q);
        host.frame(2'b11, 16'h0000, q);
        cmp($sformatf("reg %h", a), {32'h0, e}, {32'h0, q});
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] a [7] = '{16'hB006, 16'hB00B, 16'hB400, 16'hB410, 16'hB420, 16'hB490, 16'hB495};
        foreach (a[i])
            rd(a[i], 16'h0000);
        rd(16'h8074, 16'h0011);
    endtask
    task automatic t_tick();
        logic [47:0] n;
        wr(16'hB006, 16'h0002);
        rd(16'hB006, 16'h0002);
        pin2 = 1'b1;
        itick = 1'b1;
        @(negedge clk);
        itick = 1'b0;
        cmp("tick internal", 48'h1, {47'h0, ptick});
        repeat (4) @(negedge clk);
        cmp("pin two ctl", 48'h0, {47'h0, p2ctl});
        wr(16'hB00B, 16'h0400);
        pin2 = 1'b0;
        itick = 1'b1;
        @(negedge clk);
        itick = 1'b0;
        pin2 = 1'b1;
        n = 48'h0;
        repeat (8) begin
            @(negedge clk);
            n = n + {47'h0, ptick};
        end
        cmp("tick pin pulses", 48'h1, n);
        wr(16'hB006, 16'h0000);
        cmp("pin two ctl", 48'h1, {47'h0, p2ctl});
    endtask
    task automatic t_shutter();
        logic [15:0] v [4] = '{16'hD954, 16'hD955, 16'h8000, 16'h7FFF};
        logic [47:0] e [4] = '{48'h1, 48'h0, 48'h1, 48'h0};
        foreach (v[i]) begin
            wr(16'hB410, v[i]);
            cmp("setpoint", {32'h0, v[i]}, {32'h0, pset});
            cmp("shutter", e[i], {47'h0, shut});
        end
    endtask
    task automatic t_hires();
        for (int i = 0; i < 6; i++)
            wr(16'hB490 + 16'(i), 16'hA100 + 16'(i));
        for (int i = 0; i < 6; i++)
            rd(16'hB490 + 16'(i), 16'hA100 + 16'(i));
        cmp("tx legacy", txl, txm);
        wr(16'hB400, 16'hFFFF);
        rd(16'hB400, 16'h0400);
        cmp("tx hires", 48'hA100A101A102, txm);
        cmp("tx mode", 48'h1, {47'h0, txh});
        cmp("rx legacy", rxl, rxm);
        wr(16'hB420, 16'h0400);
        cmp("rx hires", 48'hA103A104A105, rxm);
        cmp("rx mode", 48'h1, {47'h0, rxh});
        wr(16'hB400, 16'h0000);
        cmp("tx back", txl, txm);
    endtask
    task automatic t_cur();
        logic [95:0] c;
        logic [15:0] q;
        c = {txc, rxc};
        for (int i = 0; i < 6; i++)
            rd(16'hB496 + 16'(i), c[95-16*i -: 16]);
        wr(16'hB497, 16'h5555);
        rd(16'hB497, txc[31:16]);
        rd(16'hB49C, 16'h0000);
        // Read-and-increment walks the receive triplet without new address frames.
        host.frame(2'b00, 16'hB499, q);
        for (int i = 0; i < 3; i++) begin
            host.frame(2'b10, 16'h0000, q);
            cmp("rdinc", {32'h0, rxc[47-16*i -: 16]}, {32'h0, q});
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_tick();
        t_shutter();
        t_hires();
        t_cur();
        close_out();
    end
    // About 41 register accesses of two frames each, plus four single frames, fit well inside this span.
    initial begin
        repeat (70000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
